//--- verilog/ctb_counter_map.svh
`ifndef CTB_COUNTER_MAP_SVH
`define CTB_COUNTER_MAP_SVH
// ***********************************
// register locations on the 8-bit bus
// ***********************************
`define CTB_OFS_CTRL_A   6'h00
`define CTB_OFS_CTRL_B   6'h01
`define CTB_OFS_FLAGS    6'h02
`define CTB_OFS_CNT_L    6'h04
`define CTB_OFS_CNT_H    6'h05
`define CTB_OFS_CAP_L    6'h06
`define CTB_OFS_CAP_H    6'h07
`define CTB_OFS_CMPA_L   6'h08
`define CTB_OFS_CMPA_H   6'h09
`define CTB_OFS_CMPB_L   6'h0A
`define CTB_OFS_CMPB_H   6'h0B
// ***********************************
// field positions
// ***********************************
`define CTB_A_WGM_LO     1:0
`define CTB_B_CS         2:0
`define CTB_B_WGM_HI     4:3
`define CTB_F_OVF        0
// ***********************************
// reset values and fixed peaks
// ***********************************
`define CTB_RST_BYTE     8'h00
`define CTB_RST_WORD     16'h0000
`define CTB_PEAK_8B      16'h00FF
`define CTB_PEAK_9B      16'h01FF
`define CTB_PEAK_10B     16'h03FF
`define CTB_PEAK_MAX     16'hFFFF
`define CTB_WORD_ONE     16'h0001
`endif

//--- verilog/ctb_pkg.sv
`default_nettype none
package ctb_pkg;
   typedef struct packed
   {
      logic       rd;
      logic       wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } ctb_bus_req_t;

   typedef struct packed
   {
      logic floor_reached;
      logic peak_reached;
      logic count_down;
      logic overflow_irq;
   } ctb_status_t;
endpackage : ctb_pkg
`default_nettype wire

//--- verilog/ctb_counter16.sv
// Notes on behaviour
// - high-byte writes and counter/capture high-byte reads go to the shared latch, never the counter directly
// - low-byte read copies the counter's high byte into the latch same cycle
// - low-byte write loads counter from latch plus written low byte
// - whole 16-bit value moves in one clock cycle, read or write
// - three-bit clock select in control B chooses the tick source
// - clock select zero gives no tick, counter holds
// - counter readable and writable with or without ticks
// - processor write beats clear or count in the same cycle
// - each tick clears, increments or decrements per mode
// - count steps by exactly one, direction picks up or down
// - clear forces all sixteen bits to zero
// - floor signal high while counter is zero
// - peak signal high while counter equals sequence peak
// - four-bit waveform mode split over control A and B
// - overflow flag set per mode, offered as interrupt source
// - one latch serves counter, both compare and capture registers
// - compare high-byte reads come direct, latch untouched
// - peak is 0x00FF, 0x01FF, 0x03FF, 0xFFFF, compare A or capture
`timescale 1ns/100ps
`default_nettype none
`include "ctb_counter_map.svh"
module ctb_counter16
(
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire ctb_pkg::ctb_bus_req_t bus_req,
   input  wire logic [7:1]          tick_src,
   input  wire logic                capture_evt,
   output var  logic [7:0]          rdata,
   output var  ctb_pkg::ctb_status_t status,
   output var  logic [15:0]         count_value,
   output var  logic [15:0]         cmpa_value,
   output var  logic [15:0]         cmpb_value,
   output var  logic                timer_tick
);
   import ctb_pkg::*;

   // ***********************************
   // state
   // ***********************************
   logic [7:0]  ctrl_a_r,  ctrl_a_nxt;
   logic [7:0]  ctrl_b_r,  ctrl_b_nxt;
   logic [7:0]  temp_r,    temp_nxt;
   logic [15:0] cnt_r,     cnt_nxt;
   logic [15:0] cmpa_r,    cmpa_nxt;
   logic [15:0] cmpb_r,    cmpb_nxt;
   logic [15:0] cap_r,     cap_nxt;
   logic        down_r,    down_nxt;
   logic        ovf_r,     ovf_nxt;
   logic        floor_r,   floor_nxt;
   logic        peak_r,    peak_nxt;
   logic        tick_r,    tick_nxt;
   logic [7:0]  rdata_r,   rdata_nxt;

   logic [3:0]  mode;
   logic [3:0]  mode_nxt;
   logic [2:0]  csel;
   logic        tick;
   logic        dual;
   logic        ctc;
   logic        cap_top;
   logic [15:0] peak_val;
   logic        cnt_wr;
   logic        ovf_evt;

   // ***********************************
   // mode decode
   // ***********************************
   function automatic logic [15:0] peak_of(input logic [3:0]  m,
                                           input logic [15:0] ca,
                                           input logic [15:0] ic);
      case (m)
         4'd1, 4'd5:                  peak_of = `CTB_PEAK_8B;
         4'd2, 4'd6:                  peak_of = `CTB_PEAK_9B;
         4'd3, 4'd7:                  peak_of = `CTB_PEAK_10B;
         4'd4, 4'd9, 4'd11, 4'd15:    peak_of = ca;
         4'd8, 4'd10, 4'd12, 4'd14:   peak_of = ic;
         default:                     peak_of = `CTB_PEAK_MAX;
      endcase
   endfunction : peak_of

   always_comb
   begin
      mode     = {ctrl_b_r[`CTB_B_WGM_HI], ctrl_a_r[`CTB_A_WGM_LO]};
      csel     = ctrl_b_r[`CTB_B_CS];
      tick     = (csel != 3'd0) && tick_src[csel];
      dual     = (mode inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11});
      ctc      = (mode == 4'd4) || (mode == 4'd12);
      cap_top  = (mode inside {4'd8, 4'd10, 4'd12, 4'd14});
      peak_val = peak_of(mode, cmpa_r, cap_r);
      cnt_wr   = bus_req.wr && (bus_req.addr == `CTB_OFS_CNT_L);
   end

   // ***********************************
   // next values
   // ***********************************
   always_comb
   begin
      ctrl_a_nxt = ctrl_a_r;
      ctrl_b_nxt = ctrl_b_r;
      temp_nxt   = temp_r;
      cnt_nxt    = cnt_r;
      cmpa_nxt   = cmpa_r;
      cmpb_nxt   = cmpb_r;
      cap_nxt    = cap_r;
      down_nxt   = down_r;
      ovf_evt    = 1'b0;
      rdata_nxt  = rdata_r;

      // counting
      if (tick)
      begin
         if (dual)
         begin
            if (!down_r)
            begin
               if (cnt_r >= peak_val)
               begin
                  down_nxt = 1'b1;
                  cnt_nxt  = cnt_r - `CTB_WORD_ONE;
               end
               else
               begin
                  cnt_nxt = cnt_r + `CTB_WORD_ONE;
               end
            end
            else if (cnt_r == `CTB_RST_WORD)
            begin
               down_nxt = 1'b0;
               cnt_nxt  = cnt_r + `CTB_WORD_ONE;
               ovf_evt  = 1'b1;
            end
            else
            begin
               cnt_nxt = cnt_r - `CTB_WORD_ONE;
            end
         end
         else
         begin
            down_nxt = 1'b0;
            if (cnt_r == peak_val)
            begin
               cnt_nxt = `CTB_RST_WORD;
            end
            else
            begin
               cnt_nxt = cnt_r + `CTB_WORD_ONE;
            end
            if (ctc)
            begin
               ovf_evt = (cnt_r == `CTB_PEAK_MAX);
            end
            else
            begin
               ovf_evt = (cnt_r == peak_val);
            end
         end
      end

      if (capture_evt && !cap_top)
      begin
         cap_nxt = cnt_r;
      end

      // bus writes
      if (bus_req.wr)
      begin
         case (bus_req.addr)
            `CTB_OFS_CTRL_A: ctrl_a_nxt = bus_req.wdata;
            `CTB_OFS_CTRL_B: ctrl_b_nxt = bus_req.wdata;
            `CTB_OFS_CNT_H,
            `CTB_OFS_CAP_H,
            `CTB_OFS_CMPA_H,
            `CTB_OFS_CMPB_H: temp_nxt = bus_req.wdata;
            `CTB_OFS_CNT_L:  cnt_nxt = {temp_r, bus_req.wdata};
            `CTB_OFS_CMPA_L: cmpa_nxt = {temp_r, bus_req.wdata};
            `CTB_OFS_CMPB_L: cmpb_nxt = {temp_r, bus_req.wdata};
            `CTB_OFS_CAP_L:
            begin
               if (cap_top)
               begin
                  cap_nxt = {temp_r, bus_req.wdata};
               end
            end
            default: ;
         endcase
      end

      // bus reads
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            `CTB_OFS_CTRL_A: rdata_nxt = ctrl_a_r;
            `CTB_OFS_CTRL_B: rdata_nxt = ctrl_b_r;
            `CTB_OFS_FLAGS:  rdata_nxt = {7'h00, ovf_r};
            `CTB_OFS_CNT_L:
            begin
               rdata_nxt = cnt_r[7:0];
               temp_nxt  = cnt_r[15:8];
            end
            `CTB_OFS_CAP_L:
            begin
               rdata_nxt = cap_r[7:0];
               temp_nxt  = cap_r[15:8];
            end
            `CTB_OFS_CNT_H,
            `CTB_OFS_CAP_H:  rdata_nxt = temp_r;
            `CTB_OFS_CMPA_L: rdata_nxt = cmpa_r[7:0];
            `CTB_OFS_CMPA_H: rdata_nxt = cmpa_r[15:8];
            `CTB_OFS_CMPB_L: rdata_nxt = cmpb_r[7:0];
            `CTB_OFS_CMPB_H: rdata_nxt = cmpb_r[15:8];
            default:         rdata_nxt = 8'h00;
         endcase
      end

      // flag: write one clears, new event wins
      ovf_nxt = ovf_r;
      if (bus_req.wr && (bus_req.addr == `CTB_OFS_FLAGS) && bus_req.wdata[`CTB_F_OVF])
      begin
         ovf_nxt = 1'b0;
      end
      if (ovf_evt && !cnt_wr)
      begin
         ovf_nxt = 1'b1;
      end

      mode_nxt  = {ctrl_b_nxt[`CTB_B_WGM_HI], ctrl_a_nxt[`CTB_A_WGM_LO]};
      floor_nxt = (cnt_nxt == `CTB_RST_WORD);
      peak_nxt  = (cnt_nxt == peak_of(mode_nxt, cmpa_nxt, cap_nxt));
      tick_nxt  = tick;
   end

   // ***********************************
   // registers
   // ***********************************
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_a_r <= `CTB_RST_BYTE;
         ctrl_b_r <= `CTB_RST_BYTE;
         temp_r   <= `CTB_RST_BYTE;
         cnt_r    <= `CTB_RST_WORD;
         cmpa_r   <= `CTB_RST_WORD;
         cmpb_r   <= `CTB_RST_WORD;
         cap_r    <= `CTB_RST_WORD;
         down_r   <= 1'b0;
         ovf_r    <= 1'b0;
         floor_r  <= 1'b1;
         peak_r   <= 1'b0;
         tick_r   <= 1'b0;
         rdata_r  <= `CTB_RST_BYTE;
      end
      else
      begin
         ctrl_a_r <= ctrl_a_nxt;
         ctrl_b_r <= ctrl_b_nxt;
         temp_r   <= temp_nxt;
         cnt_r    <= cnt_nxt;
         cmpa_r   <= cmpa_nxt;
         cmpb_r   <= cmpb_nxt;
         cap_r    <= cap_nxt;
         down_r   <= down_nxt;
         ovf_r    <= ovf_nxt;
         floor_r  <= floor_nxt;
         peak_r   <= peak_nxt;
         tick_r   <= tick_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   always_comb
   begin
      rdata                = rdata_r;
      count_value          = cnt_r;
      cmpa_value           = cmpa_r;
      cmpb_value           = cmpb_r;
      timer_tick           = tick_r;
      status.floor_reached = floor_r;
      status.peak_reached  = peak_r;
      status.count_down    = down_r;
      status.overflow_irq  = ovf_r;
   end

   // ***********************************
   // checks
   // ***********************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_low_read_latch: assert property (
      bus_req.rd && bus_req.addr == `CTB_OFS_CNT_L |=> temp_r == $past(cnt_r[15:8])
      && rdata_r == $past(cnt_r[7:0])) else $error("low read did not latch high byte");
   a_low_write_load: assert property (
      cnt_wr |=> cnt_r == {$past(temp_r), $past(bus_req.wdata)})
      else $error("low write did not load full word");
   a_high_write_temp: assert property (
      bus_req.wr && bus_req.addr == `CTB_OFS_CNT_H && !tick |=> temp_r == $past(bus_req.wdata)
      && $stable(cnt_r)) else $error("high write reached counter");
   a_stop_holds: assert property (
      csel == 3'd0 && !cnt_wr |=> $stable(cnt_r)) else $error("counter moved without tick");
   a_step_one: assert property (
      tick && !cnt_wr |=> cnt_r == $past(cnt_r) + 16'h0001
      || cnt_r == $past(cnt_r) - 16'h0001 || cnt_r == 16'h0000)
      else $error("counter step not one");
   a_floor_signal: assert property (
      floor_r == (cnt_r == 16'h0000)) else $error("floor signal wrong");
   a_peak_signal: assert property (
      peak_r == (cnt_r == peak_val)) else $error("peak signal wrong");
   a_cmp_read_direct: assert property (
      bus_req.rd && bus_req.addr == `CTB_OFS_CMPA_H |=> rdata_r == $past(cmpa_r[15:8])
      && $stable(temp_r)) else $error("compare read used latch");
   a_ovf_sets: assert property (
      ovf_evt && !cnt_wr |=> ovf_r) else $error("overflow flag not set");
   a_temp_keeps: assert property (
      !bus_req.rd && !bus_req.wr |=> $stable(temp_r)) else $error("latch changed idle");
endmodule : ctb_counter16
`default_nettype wire

//--- dv/ctb_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module ctb_cpu_model
(
   input  wire logic                  clk,
   output var  ctb_pkg::ctb_bus_req_t bus_req
);
   import ctb_pkg::*;
   initial bus_req = '0;
   task automatic put(input logic r, input logic w, input logic [5:0] a, input logic [7:0] d);
      bus_req <= '{rd: r, wr: w, addr: a, wdata: d};
   endtask : put
   // released lines show inverted values, never the last ones
   task automatic idle();
      @(posedge clk);
      bus_req <= '{rd: 1'b0, wr: 1'b0, addr: ~bus_req.addr, wdata: ~bus_req.wdata};
   endtask : idle
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      put(1'b0, 1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [5:0] a);
      @(posedge clk);
      put(1'b1, 1'b0, a, ~bus_req.wdata);
   endtask : rd
   // high byte first, nothing else in between
   task automatic wr16(input logic [5:0] lo_a, input logic [15:0] v);
      wr(lo_a + 6'h01, v[15:8]);
      wr(lo_a, v[7:0]);
   endtask : wr16
endmodule : ctb_cpu_model
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ctb_counter_map.svh"
module tb_top;
   import ctb_pkg::*;
   logic                  clk;
   logic                  arst_n;
   ctb_bus_req_t          bus_req;
   logic [7:1]            tick_src;
   logic                  capture_evt;
   logic [7:0]            rdata;
   ctb_status_t           status;
   logic [15:0]           count_value;
   logic [15:0]           cmpa_value;
   logic [15:0]           cmpb_value;
   logic                  timer_tick;
   int                    errors;
   int                    tests_run;
   logic [31:0]           seed;
   logic [7:0]            exp_q[$];
   logic [15:0]           v;
   logic [15:0]           c;
   logic [3:0]            wm[4];
   logic [15:0]           pk[4];

   ctb_cpu_model ctb_cpu_model_i (.clk(clk), .bus_req(bus_req));
   ctb_counter16 ctb_counter16_i (.clk(clk), .arst_n(arst_n), .bus_req(bus_req),
      .tick_src(tick_src), .capture_evt(capture_evt), .rdata(rdata), .status(status),
      .count_value(count_value), .cmpa_value(cmpa_value), .cmpb_value(cmpb_value),
      .timer_tick(timer_tick));

   initial clk = 1'b0;
   always #20 clk = ~clk;

   task automatic report_and_stop();
      if (errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // *****************
   // read data watcher
   // *****************
   always @(posedge clk)
   begin
      if (bus_req.rd === 1'b1)
      begin
         #1;
         if (exp_q.size() > 0)
            chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
      end
   end

   function automatic logic [31:0] rnd(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : rnd
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      ctb_cpu_model_i.rd(a);
   endtask : rd
   task automatic tick(input logic [7:1] m);
      @(posedge clk);
      tick_src <= m;
      @(posedge clk);
      tick_src <= 7'h00;
      @(negedge clk);
   endtask : tick
   task automatic mode(input logic [3:0] w, input logic [2:0] cs);
      ctb_cpu_model_i.wr(`CTB_OFS_CTRL_A, {6'h00, w[1:0]});
      ctb_cpu_model_i.wr(`CTB_OFS_CTRL_B, {3'h0, w[3:2], cs});
   endtask : mode
   task automatic set_cnt(input logic [15:0] x);
      ctb_cpu_model_i.wr16(`CTB_OFS_CNT_L, x);
      ctb_cpu_model_i.idle();
      @(negedge clk);
   endtask : set_cnt

   initial
   begin
      #100000;
      errors++;
      report_and_stop();
   end

   initial
   begin
      arst_n = 1'b0;
      tick_src = 7'h00;
      capture_evt = 1'b0;
      seed = 32'hc624deb6;
      wm = '{4'd5, 4'd6, 4'd7, 4'd4};
      pk = '{`CTB_PEAK_8B, `CTB_PEAK_9B, `CTB_PEAK_10B, 16'h0040};
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      chk("count", `CTB_RST_WORD, count_value);
      chk("floor", 16'h0001, {15'h0, status.floor_reached});
      seed = rnd(seed);
      v = seed[15:0];
      set_cnt(v);
      chk("count", v, count_value);
      tick(7'h7F);
      chk("count", v, count_value);
      rd(`CTB_OFS_CNT_L, v[7:0]);
      rd(`CTB_OFS_CNT_H, v[15:8]);
      ctb_cpu_model_i.wr(`CTB_OFS_CNT_H, ~v[15:8]);
      ctb_cpu_model_i.idle();
      @(negedge clk);
      chk("count", v, count_value);
      rd(`CTB_OFS_CNT_H, ~v[15:8]);
      c = v ^ 16'h5A00;
      ctb_cpu_model_i.wr16(`CTB_OFS_CMPA_L, c);
      rd(`CTB_OFS_CNT_L, v[7:0]);
      rd(`CTB_OFS_CMPA_H, c[15:8]);
      rd(`CTB_OFS_CNT_H, v[15:8]);
      chk("cmpa", c, cmpa_value);
      rd(6'h3F, 8'h00);
      seed = rnd(seed);
      ctb_cpu_model_i.wr(`CTB_OFS_CNT_H, seed[23:16]);
      ctb_cpu_model_i.wr(`CTB_OFS_CNT_L, seed[7:0]);
      ctb_cpu_model_i.wr(`CTB_OFS_CMPB_L, seed[15:8]);
      ctb_cpu_model_i.idle();
      @(negedge clk);
      chk("count", {seed[23:16], seed[7:0]}, count_value);
      chk("cmpb", seed[23:8], cmpb_value);
      for (int k = 1; k < 8; k++)
      begin
         seed = rnd(seed);
         mode(4'd0, 3'(k));
         set_cnt(seed[15:0]);
         tick(~(7'h01 << (k - 1)));
         chk("count", seed[15:0], count_value);
         chk("tick", 16'h0000, {15'h0, timer_tick});
         tick(7'h01 << (k - 1));
         chk("count", seed[15:0] + `CTB_WORD_ONE, count_value);
         chk("tick", 16'h0001, {15'h0, timer_tick});
      end
      mode(4'd0, 3'd1);
      ctb_cpu_model_i.wr(`CTB_OFS_CNT_H, v[15:8]);
      @(posedge clk);
      ctb_cpu_model_i.put(1'b0, 1'b1, `CTB_OFS_CNT_L, v[7:0]);
      tick_src <= 7'h01;
      ctb_cpu_model_i.idle();
      tick_src <= 7'h00;
      @(negedge clk);
      chk("count", v, count_value);
      @(posedge clk);
      capture_evt <= 1'b1;
      @(posedge clk);
      capture_evt <= 1'b0;
      rd(`CTB_OFS_CAP_L, v[7:0]);
      rd(`CTB_OFS_CAP_H, v[15:8]);
      ctb_cpu_model_i.wr16(`CTB_OFS_CMPA_L, 16'h0040);
      for (int i = 0; i < 4; i++)
      begin
         mode(wm[i], 3'd1);
         ctb_cpu_model_i.wr(`CTB_OFS_FLAGS, 8'h01);
         set_cnt(pk[i] - `CTB_WORD_ONE);
         tick(7'h01);
         chk("count", pk[i], count_value);
         chk("peak", 16'h0001, {15'h0, status.peak_reached});
         tick(7'h01);
         chk("count", `CTB_RST_WORD, count_value);
         chk("floor", 16'h0001, {15'h0, status.floor_reached});
         chk("ovf", {15'h0, i < 3}, {15'h0, status.overflow_irq});
         rd(`CTB_OFS_FLAGS, {7'h00, i < 3});
         ctb_cpu_model_i.wr(`CTB_OFS_FLAGS, 8'h01);
         ctb_cpu_model_i.idle();
         @(negedge clk);
         chk("ovf", 16'h0000, {15'h0, status.overflow_irq});
      end
      mode(4'd1, 3'd1);
      rd(`CTB_OFS_CTRL_A, 8'h01);
      rd(`CTB_OFS_CTRL_B, 8'h01);
      set_cnt(16'h00FE);
      tick(7'h01);
      chk("count", `CTB_PEAK_8B, count_value);
      tick(7'h01);
      chk("count", 16'h00FE, count_value);
      chk("down", 16'h0001, {15'h0, status.count_down});
      repeat (3) @(posedge clk);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
